// ### src/ads_setup_defs.vh
// Constants for the device setup register block
`ifndef ADS_SETUP_DEFS_VH
`define ADS_SETUP_DEFS_VH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define ADS_DEVICE_SETUP_IDX    12'h020
`define ADS_DEVICE_SETUP_ADDR   12'h080
`define ADS_FLAG_STATUS_ADDR    12'h084
`define ADS_EVENT_CTRL_ADDR     12'h088
`define ADS_DEVICE_SETUP_RST    8'h10

// ---------------------------------------------------------------------------
// Field positions in device_setup
// ---------------------------------------------------------------------------
`define ADS_BIT_CLEAR_POLICY    7
`define ADS_BIT_IDLE_BEHAVIOUR  6
`define ADS_BIT_STATUS_APPEND   5
`define ADS_BIT_REGULATOR_ON    4
`define ADS_BIT_RESERVED_HI     3
`define ADS_BIT_INTERFACE_MODE  2
`define ADS_BIT_CYCLE_SELECT    1
`define ADS_BIT_RESERVED_LO     0

// ---------------------------------------------------------------------------
// Event control word fields
// ---------------------------------------------------------------------------
`define ADS_BIT_CFG_CMD         0

`endif

// ### src/ads_setup.v
// Device setup register with limit flag store, reached over APB
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ads_setup_defs.vh"

module ads_setup (
  input  wire        pclk,                  // Bus clock, 10 MHz
  input  wire        presetn,               // Asynchronous reset, active low
  input  wire        psel,                  // APB select
  input  wire        penable,               // APB access phase
  input  wire        pwrite,                // APB direction, high for write
  input  wire [11:0] paddr,                 // APB byte address
  input  wire [31:0] pwdata,                // APB write data
  input  wire [3:0]  pstrb,                 // APB byte strobes
  output wire        pready,                // APB ready, always high
  output reg  [31:0] prdata,                // APB read data
  output wire        pslverr,               // APB error on unmapped address
  input  wire        cfg_mode_cmd,          // Configuration mode command pulse
  input  wire [7:0]  upper_limit_hit,       // Per-channel upper threshold hit pulses
  input  wire [7:0]  lower_limit_hit,       // Per-channel lower threshold hit pulses
  input  wire [7:0]  in_hysteresis_band,    // Per-channel result back inside band
  output reg         hysteresis_clear_off,  // Clearing policy, high: no hysteresis
  output reg         output_idle_behaviour, // High: busy indication on data outputs
  output reg         status_append,         // High: status bits follow results
  output reg         internal_regulator_on, // Internal regulator enable
  output reg         conversion_mode,       // High: interface in conversion mode
  output reg         command_cycle_select,  // High: single-cycle command mode
  output reg  [7:0]  upper_limit_flag,      // Sticky upper limit flags
  output reg  [7:0]  lower_limit_flag       // Sticky lower limit flags
);

  // -------------------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------------------
  // Decode shared by write and read paths
  function [1:0] dec;
    input [11:0] a;
    begin
      case (a)
        `ADS_DEVICE_SETUP_ADDR: dec = 2'h1;
        `ADS_FLAG_STATUS_ADDR:  dec = 2'h2;
        `ADS_EVENT_CTRL_ADDR:   dec = 2'h3;
        default:                dec = 2'h0;
      endcase
    end
  endfunction

  wire       acc      = psel & penable;
  wire [1:0] sel      = dec(paddr);
  wire       wr_setup = acc & pwrite & (sel == 2'h1) & pstrb[0];
  wire       wr_ctrl  = acc & pwrite & (sel == 2'h3) & pstrb[0];
  wire       rd_flags = acc & ~pwrite & (sel == 2'h2);

  // Zero wait states keep the bus simple; nothing here is slow
  assign pready  = 1'b1;
  assign pslverr = acc & (sel == 2'h0);

  // -------------------------------------------------------------------------
  // Setup register
  // -------------------------------------------------------------------------
  reg  [7:0] setup_r;
  reg  [7:0] setup_nxt;
  wire       cfg_cmd = cfg_mode_cmd | (wr_ctrl & pwdata[`ADS_BIT_CFG_CMD]);

  // Write first, then the command clear of the mode bit overrides it
  always @* begin
    setup_nxt = setup_r;
    if (wr_setup) begin
      setup_nxt = pwdata[7:0];
    end
    if (cfg_cmd) begin
      setup_nxt[`ADS_BIT_INTERFACE_MODE] = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_r <= `ADS_DEVICE_SETUP_RST;
    end else begin
      setup_r <= setup_nxt;
    end
  end

  // Field outputs registered from the next value so they track setup_r
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hysteresis_clear_off  <= 1'b0;
      output_idle_behaviour <= 1'b0;
      status_append         <= 1'b0;
      internal_regulator_on <= 1'b1;
      conversion_mode       <= 1'b0;
      command_cycle_select  <= 1'b0;
    end else begin
      hysteresis_clear_off  <= setup_nxt[`ADS_BIT_CLEAR_POLICY];
      output_idle_behaviour <= setup_nxt[`ADS_BIT_IDLE_BEHAVIOUR];
      status_append         <= setup_nxt[`ADS_BIT_STATUS_APPEND];
      internal_regulator_on <= setup_nxt[`ADS_BIT_REGULATOR_ON];
      conversion_mode       <= setup_nxt[`ADS_BIT_INTERFACE_MODE];
      command_cycle_select  <= setup_nxt[`ADS_BIT_CYCLE_SELECT];
    end
  end

  // -------------------------------------------------------------------------
  // Limit flags
  // -------------------------------------------------------------------------
  // Set wins over a read clear, yet a hit taken at the read's setup-phase edge misses prdata and is then cleared;
  // the band clear only acts with hysteresis in use (policy bit low)
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flag
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          upper_limit_flag[g] <= 1'b0;
          lower_limit_flag[g] <= 1'b0;
        end else begin
          if (upper_limit_hit[g]) begin
            upper_limit_flag[g] <= 1'b1;
          end else if (rd_flags) begin
            upper_limit_flag[g] <= 1'b0;
          end else if (!setup_r[`ADS_BIT_CLEAR_POLICY] && in_hysteresis_band[g]) begin
            upper_limit_flag[g] <= 1'b0;
          end
          if (lower_limit_hit[g]) begin
            lower_limit_flag[g] <= 1'b1;
          end else if (rd_flags) begin
            lower_limit_flag[g] <= 1'b0;
          end else if (!setup_r[`ADS_BIT_CLEAR_POLICY] && in_hysteresis_band[g]) begin
            lower_limit_flag[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------------
  // Registered in the setup phase so data is stable in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (sel)
        2'h1:    prdata <= {24'h00_0000, setup_nxt};
        2'h2:    prdata <= {16'h0000, upper_limit_flag, lower_limit_flag};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // ads_setup

`default_nettype wire

// ### test/ads_chk_checker.sv
// Checker for the device setup register ports
`timescale 1ns/1ps
`default_nettype none
module ads_chk (
  input wire logic        pclk,                  // Clock
  input wire logic        presetn,               // Reset
  input wire logic        psel,                  // Select
  input wire logic        penable,               // Access
  input wire logic        pwrite,                // Write
  input wire logic [11:0] paddr,                 // Address
  input wire logic [31:0] pwdata,                // Data
  input wire logic [3:0]  pstrb,                 // Strobes
  input wire logic        pready,                // Ready
  input wire logic        cfg_mode_cmd,          // Command
  input wire logic        hysteresis_clear_off,  // Bit 7
  input wire logic        output_idle_behaviour, // Bit 6
  input wire logic        status_append,         // Bit 5
  input wire logic        internal_regulator_on, // Bit 4
  input wire logic        conversion_mode,       // Bit 2
  input wire logic        command_cycle_select   // Bit 1
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup write taken at this edge
  wire wr = psel && penable && pwrite && paddr == 12'h080 && pstrb[0];
  ready_high_a: assert property (pready) else $error("pready low");
  policy_write_a: assert property (wr |=> hysteresis_clear_off == $past(pwdata[7])) else $error("bit 7");
  idle_write_a: assert property (wr |=> output_idle_behaviour == $past(pwdata[6])) else $error("bit 6");
  append_write_a: assert property (wr |=> status_append == $past(pwdata[5])) else $error("bit 5");
  regulator_hold_a: assert property (!wr |=> $stable(internal_regulator_on)) else $error("bit 4");
  mode_write_a: assert property (wr && !cfg_mode_cmd |=> conversion_mode == $past(pwdata[2])) else $error("bit 2");
  cfg_clear_a: assert property (cfg_mode_cmd |=> !conversion_mode) else $error("cfg command");
  cycle_write_a: assert property (wr |=> command_cycle_select == $past(pwdata[1])) else $error("bit 1");
endmodule // ads_chk
`default_nettype wire

// ### test/ads_host.sv
// Host model: APB master toward the setup register
`timescale 1ns/1ps
`default_nettype none
module ads_host (
  input  wire logic        pclk,    // Clock
  input  wire logic        pready,  // Ready
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pslverr, // Error response
  output var  logic        psel,    // Select
  output var  logic        penable, // Access
  output var  logic        pwrite,  // Write
  output var  logic [11:0] paddr,   // Address
  output var  logic [31:0] pwdata,  // Write data
  output var  logic [3:0]  pstrb    // Strobes
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // One transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hf};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
endmodule // ads_host
`default_nettype wire

// ### test/tb.sv
// Top testbench for the device setup register
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, cfg_mode_cmd = 0;
  logic [7:0] upper_limit_hit = 0, lower_limit_hit = 0, in_hysteresis_band = 0;
  wire psel, penable, pwrite, pready, pslverr, hysteresis_clear_off, output_idle_behaviour, status_append;
  wire internal_regulator_on, conversion_mode, command_cycle_select;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb;
  wire [7:0] upper_limit_flag, lower_limit_flag;
  wire [31:0] fo = {26'h0, hysteresis_clear_off, output_idle_behaviour, status_append,
                    internal_regulator_on, conversion_mode, command_cycle_select};
  logic [31:0] q, v;
  logic se;
  int failures = 0, samples_checked = 0;
  // Bus clock, 100 ns period
  always #50 pclk = ~pclk;
  ads_setup ads_setup_i (.*);
  ads_host ads_host_i (.*);
  task automatic chk(input string n, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] fx(input logic [7:0] x);
    return {26'h0, x[7:4], x[2:1]};
  endfunction
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    ads_host_i.xfer(1'b0, a, 32'h0, q, se);
    chk(n, e, q);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ads_host_i.xfer(1'b1, a, d, q, se);
  endtask
  task end_sim;
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: run needs about 15 us, allow over six times that
  initial begin
    #100000;
    failures++;
    end_sim;
  end
  // Main sequence
  initial begin
    void'($urandom(8971));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h080, 32'h10, "reset value");
    chk("reset fields", fx(8'h10), fo);
    repeat (16) begin
      v = $urandom;
      wr(12'h080, v);
      rd(12'h080, v & 32'hff, "setup");
      chk("fields", fx(v[7:0]), fo);
    end
    wr(12'h080, 32'h16);
    cfg_mode_cmd <= 1'b1;
    @(posedge pclk);
    cfg_mode_cmd <= 1'b0;
    rd(12'h080, 32'h12, "cfg command");
    wr(12'h080, 32'h04);
    wr(12'h088, 32'h1);
    rd(12'h080, 32'h0, "event command");
    wr(12'h0fc, 32'hff);
    chk("slverr", 32'h1, {31'h0, se});
    rd(12'h0fc, 32'h0, "unmapped");
    rd(12'h080, 32'h0, "after unmapped");
    chk("no slverr", 32'h0, {31'h0, se});
    $display("register tests done");
    v = $urandom;
    upper_limit_hit <= v[7:0];
    lower_limit_hit <= v[15:8];
    @(posedge pclk);
    upper_limit_hit <= 8'h0;
    lower_limit_hit <= 8'h0;
    rd(12'h084, {16'h0, v[7:0], v[15:8]}, "flags");
    rd(12'h084, 32'h0, "flags cleared");
    // Flag outputs and band clear with hysteresis in use, then with it off
    upper_limit_hit <= 8'h0f;
    lower_limit_hit <= 8'hf0;
    @(posedge pclk);
    upper_limit_hit <= 8'h0;
    lower_limit_hit <= 8'h0;
    @(negedge pclk);
    chk("flag outputs", 32'h0ff0, {16'h0, upper_limit_flag, lower_limit_flag});
    @(posedge pclk);
    in_hysteresis_band <= 8'h03;
    @(posedge pclk);
    in_hysteresis_band <= 8'h00;
    @(negedge pclk);
    chk("band clear", 32'h0cf0, {16'h0, upper_limit_flag, lower_limit_flag});
    wr(12'h080, 32'h80);
    in_hysteresis_band <= 8'hff;
    @(posedge pclk);
    in_hysteresis_band <= 8'h00;
    rd(12'h084, 32'h0cf0, "no band clear");
    rd(12'h084, 32'h0, "flags cleared again");
    $display("flag tests done");
    end_sim;
  end
endmodule // tb
bind ads_setup ads_chk ads_chk_i (.*);
`default_nettype wire
